// File: src/timer2_ctrl_pkg.sv
/*
  Constants for the third timer's control block: register offsets, bit
  positions, reset values and event layout.
  Assumes a single 10 MHz core clock and a plain strobe register port.
*/
`default_nettype none
package timer2_ctrl_pkg;
  localparam int          ADDR_W            = 8;
  localparam int          DATA_W            = 8;
  localparam logic [7:0]  TIMER2_CONTROL_ADDR = 8'hC8;
  localparam logic [7:0]  BIT_SET_ADDR      = 8'hC9;
  localparam logic [7:0]  BIT_CLEAR_ADDR    = 8'hCA;
  localparam logic [7:0]  COUNT_LOW_ADDR    = 8'hCC;
  localparam logic [7:0]  COUNT_HIGH_ADDR   = 8'hCD;
  localparam logic [7:0]  MODE_ADDR         = 8'hCE;
  localparam logic [7:0]  IRQ_STATUS_ADDR   = 8'hD0;
  localparam logic [7:0]  IRQ_ENABLE_ADDR   = 8'hD1;
  localparam logic [7:0]  IRQ_CLEAR_ADDR    = 8'hD2;
  localparam logic [7:0]  CONTROL_RESET     = 8'h00;
  localparam int          OVF_BIT           = 7;
  localparam int          EXT_BIT           = 6;
  localparam int          RCLK_BIT          = 5;
  localparam int          TX_CLOCK_SELECT_BIT          = 4;
  localparam int          EXEN_BIT          = 3;
  localparam int          RUN_BIT           = 2;
  localparam int          CT_BIT            = 1;
  localparam int          CPRL_BIT          = 0;
  localparam int          MODE_UPDOWN_BIT   = 0;
  localparam int          IRQ_OVF_BIT       = 0;
  localparam int          IRQ_EXT_BIT       = 1;
  localparam int          IRQ_W             = 2;
  localparam logic [15:0] COUNT_RESET       = 16'h0000;
endpackage
`default_nettype wire

// File: src/falling_edge_sync.sv
/*
  Two-flop synchroniser with falling-edge pulse on the synchronised level.
  Assumes the input is asynchronous to clk.
*/
`default_nettype none
module falling_edge_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      level,
  output logic      fall
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // idle high so reset does not fake an edge
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign fall  = prev_reg & ~sync_reg;
endmodule
`default_nettype wire

// File: src/timer2_control_baud_select.sv
/*
  Control register, flags, counter and serial clock selection of the
  third 16-bit timer/counter.
  Assumes a CPU on a strobe port with read data one cycle later; the
  reload/capture value registers live outside, fed by the pulses here.
*/
`default_nettype none
module timer2_control_baud_select
  import timer2_ctrl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              external_trigger_pin,
  input  wire logic              count_pin,
  input  wire logic              timer1_overflow,
  output logic                   rx_baud_tick,
  output logic                   tx_baud_tick,
  output logic                   capture_pulse,
  output logic                   reload_pulse,
  output logic                   overflow_pulse,
  output logic                   irq
);
  logic [7:0]       control_reg;
  logic [7:0]       control_next;
  logic             updown_count_enable_reg;
  logic [15:0]      count_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_enable_reg;
  logic             trig_level;
  logic             trig_fall;
  logic             cnt_level;
  logic             cnt_fall;
  logic             advance;
  logic             wrap;
  logic             ext_event;
  logic             baud_mode;
  logic             overflow_flag;
  logic             external_event_flag;
  logic             rx_clock_select;
  logic             tx_clock_select;
  logic             external_trigger_enable;
  logic             run_control;
  logic             counter_timer_select;
  logic             capture_reload_select;
  logic             count_down;

  assign overflow_flag           = control_reg[OVF_BIT];
  assign external_event_flag     = control_reg[EXT_BIT];
  assign rx_clock_select         = control_reg[RCLK_BIT];
  assign tx_clock_select         = control_reg[TX_CLOCK_SELECT_BIT];
  assign external_trigger_enable = control_reg[EXEN_BIT];
  assign run_control             = control_reg[RUN_BIT];
  assign counter_timer_select    = control_reg[CT_BIT];
  assign capture_reload_select   = control_reg[CPRL_BIT];

  falling_edge_sync trig_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (external_trigger_pin),
    .level    (trig_level),
    .fall     (trig_fall)
  );

  falling_edge_sync count_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (count_pin),
    .level    (cnt_level),
    .fall     (cnt_fall)
  );

  assign baud_mode = rx_clock_select | tx_clock_select;
  // in up/down mode the trigger pin sets direction, low counts down
  assign count_down = updown_count_enable_reg & ~trig_level & ~baud_mode;

  assign advance = run_control & (counter_timer_select ? cnt_fall : 1'b1);
  assign wrap    = advance & (count_down ? (count_reg == 16'h0000) : (count_reg == 16'hFFFF));
  // trigger edge event; up/down mode uses the pin as direction instead
  assign ext_event = external_trigger_enable & trig_fall & ~updown_count_enable_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= COUNT_RESET;
    end else if (wr_en && addr == COUNT_LOW_ADDR) begin
      count_reg[7:0] <= wdata;
    end else if (wr_en && addr == COUNT_HIGH_ADDR) begin
      count_reg[15:8] <= wdata;
    end else if (advance) begin
      count_reg <= count_down ? count_reg - 16'h0001 : count_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      capture_pulse  <= 1'b0;
      reload_pulse   <= 1'b0;
      overflow_pulse <= 1'b0;
    end else begin
      overflow_pulse <= wrap;
      // capture or reload on trigger edge
      capture_pulse  <= ext_event & capture_reload_select & ~baud_mode;
      // capture/reload select ignored in baud mode: overflow always reloads
      reload_pulse   <= (ext_event & (~capture_reload_select | baud_mode)) |
                        (wrap & (~capture_reload_select | baud_mode));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_baud_tick <= 1'b0;
      tx_baud_tick <= 1'b0;
    end else begin
      rx_baud_tick <= rx_clock_select ? wrap : timer1_overflow;
      tx_baud_tick <= tx_clock_select ? wrap : timer1_overflow;
    end
  end

  // software write path first, then hardware sets override clears
  always_comb begin
    control_next = control_reg;
    if (wr_en && addr == TIMER2_CONTROL_ADDR) begin
      control_next = wdata;
    end else if (wr_en && addr == BIT_SET_ADDR) begin
      control_next[wdata[2:0]] = 1'b1;
    end else if (wr_en && addr == BIT_CLEAR_ADDR) begin
      control_next[wdata[2:0]] = 1'b0;
    end
    // overflow flag gated by baud mode
    if (wrap && !baud_mode) begin
      control_next[OVF_BIT] = 1'b1;
    end
    if (ext_event) begin
      control_next[EXT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      control_reg <= CONTROL_RESET;
    end else begin
      control_reg <= control_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      updown_count_enable_reg <= 1'b0;
    end else if (wr_en && addr == MODE_ADDR) begin
      updown_count_enable_reg <= wdata[MODE_UPDOWN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_enable_reg <= '0;
    end else if (wr_en && addr == IRQ_ENABLE_ADDR) begin
      irq_enable_reg <= wdata[IRQ_W-1:0];
    end
  end

  // sticky event log; set wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status_reg <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if (wr_en && addr == IRQ_CLEAR_ADDR && wdata[i]) begin
          irq_status_reg[i] <= 1'b0;
        end
      end
      if (wrap && !baud_mode) begin
        irq_status_reg[IRQ_OVF_BIT] <= 1'b1;
      end
      if (ext_event) begin
        irq_status_reg[IRQ_EXT_BIT] <= 1'b1;
      end
    end
  end

  // event flag requests interrupt when enabled
  // up/down mode masks the event flag
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (control_next[OVF_BIT] & irq_enable_reg[IRQ_OVF_BIT]) |
             (control_next[EXT_BIT] & irq_enable_reg[IRQ_EXT_BIT] &
              ~updown_count_enable_reg);
    end
  end

  // unmapped and write-only addresses read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd_en) begin
      if (addr == TIMER2_CONTROL_ADDR) begin
        rdata <= control_reg;
      end else if (addr == COUNT_LOW_ADDR) begin
        rdata <= count_reg[7:0];
      end else if (addr == COUNT_HIGH_ADDR) begin
        rdata <= count_reg[15:8];
      end else if (addr == MODE_ADDR) begin
        rdata <= {7'h00, updown_count_enable_reg};
      end else if (addr == IRQ_STATUS_ADDR) begin
        rdata <= {6'h00, irq_status_reg};
      end else if (addr == IRQ_ENABLE_ADDR) begin
        rdata <= {6'h00, irq_enable_reg};
      end else begin
        rdata <= '0;
      end
    end else begin
      rdata <= '0;
    end
  end
endmodule
`default_nettype wire

// File: sim/timer2_ctrl_checker.sv
/* port checker for the timer control block
   assumes sync active-high rst; bound below */
`default_nettype none
module timer2_ctrl_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       rd_en,
  input wire logic [7:0] rdata,
  input wire logic       timer1_overflow,
  input wire logic       rx_baud_tick,
  input wire logic       tx_baud_tick,
  input wire logic       capture_pulse,
  input wire logic       reload_pulse,
  input wire logic       overflow_pulse,
  input wire logic       irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  chk_rdata_idle: assert property (disable iff (rst) !$past(rd_en) |-> rdata == 8'h00)
    else $error("rdata not zero outside read slot");
  chk_reset_quiet: assert property (rst |=> !irq && rdata == 8'h00)
    else $error("irq or rdata active after reset");
  chk_reset_pulses: assert property (rst |=> !(overflow_pulse || capture_pulse || reload_pulse))
    else $error("pulse right after reset");
  chk_rx_source: assert property (disable iff (rst)
    rx_baud_tick |-> $past(timer1_overflow) || overflow_pulse)
    else $error("rx tick without source");
  chk_tx_source: assert property (disable iff (rst)
    tx_baud_tick |-> $past(timer1_overflow) || overflow_pulse)
    else $error("tx tick without source");
  chk_pulse_excl: assert property (disable iff (rst) !(capture_pulse && reload_pulse))
    else $error("capture and reload together");
  chk_ovf_single: assert property (disable iff (rst) overflow_pulse |=> !overflow_pulse)
    else $error("overflow pulse too long");
  chk_capture_single: assert property (disable iff (rst) capture_pulse |=> !capture_pulse)
    else $error("capture pulse too long");
endmodule
bind timer2_control_baud_select timer2_ctrl_checker chk_u (.clk, .rst, .rd_en, .rdata,
  .timer1_overflow, .rx_baud_tick, .tx_baud_tick, .capture_pulse, .reload_pulse,
  .overflow_pulse, .irq);
`default_nettype wire

// File: sim/serial_far_end.sv
/* serial port stand-in: counts baud ticks, makes timer 1 overflow
   assumes the timer block's clock */
`default_nettype none
module serial_far_end (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic t1_req,
  input  wire logic rx_baud_tick,
  input  wire logic tx_baud_tick,
  output var logic  timer1_overflow,
  output var int    rx_count,
  output var int    tx_count
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk) begin
    timer1_overflow <= t1_req;
  end
  always_ff @(posedge clk) begin
    rx_count <= rst ? 0 : rx_count + int'(rx_baud_tick);
    tx_count <= rst ? 0 : tx_count + int'(tx_baud_tick);
  end
endmodule
`default_nettype wire

// File: sim/testbench.sv
/* register-level bench for the timer control block
   assumes design, checker and serial stand-in compiled first */
`default_nettype none
module testbench;
  import timer2_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst, wr_en, rd_en, pin, t1_req, cpin;
  logic [7:0] addr, wdata, rdata, lo;
  logic       rxt, txt, cap, rel, ovf, irq, t1o;
  int         rxc, txc, err_count, compares, n;
  timer2_control_baud_select dut_u (.clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .external_trigger_pin(pin), .count_pin(cpin), .timer1_overflow(t1o),
    .rx_baud_tick(rxt), .tx_baud_tick(txt), .capture_pulse(cap), .reload_pulse(rel),
    .overflow_pulse(ovf), .irq);
  serial_far_end far_u (.clk, .rst, .t1_req, .rx_baud_tick(rxt), .tx_baud_tick(txt),
    .timer1_overflow(t1o), .rx_count(rxc), .tx_count(txc));
  task automatic wrap_up();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  // 0 irq, 1 reload, 2 overflow, else capture; bounded
  task automatic wait_for(input int sel);
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      #1;
      if (sel == 0 ? irq === 1'b1 : sel == 1 ? rel === 1'b1 : sel == 2 ? ovf === 1'b1
          : cap === 1'b1) break;
    end
    if (n == 200) begin
      err_count++;
      wrap_up();
    end
  endtask
  // two sync flops need the high level held a few cycles
  task automatic fall_pin();
    pin <= 1'b1;
    repeat (6) @(posedge clk);
    pin <= 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {wr_en, rd_en, pin, t1_req, cpin} = 5'b00101;
    {addr, wdata, err_count, compares} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rc(TIMER2_CONTROL_ADDR, CONTROL_RESET);
    rc(8'hD5, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(BIT_SET_ADDR, 8'(i));
      rc(TIMER2_CONTROL_ADDR, 8'h01 << i);
      wr(BIT_CLEAR_ADDR, 8'(i));
    end
    rc(TIMER2_CONTROL_ADDR, 8'h00);
    wr(COUNT_LOW_ADDR, 8'h10);
    repeat (5) @(posedge clk);
    rc(COUNT_LOW_ADDR, 8'h10);
    wr(TIMER2_CONTROL_ADDR, 8'h04);
    rd(COUNT_LOW_ADDR, lo);
    rc(COUNT_LOW_ADDR, lo + 8'h02);
    wr(COUNT_LOW_ADDR, 8'hFE);
    wr(COUNT_HIGH_ADDR, 8'hFF);
    wr(IRQ_ENABLE_ADDR, 8'h01);
    wait_for(0);
    rc(TIMER2_CONTROL_ADDR, 8'h84);
    rc(IRQ_STATUS_ADDR, 8'h01);
    wr(IRQ_CLEAR_ADDR, 8'h01);
    wr(BIT_CLEAR_ADDR, 8'h07);
    rc(TIMER2_CONTROL_ADDR, 8'h04);
    // baud mode first, so the wrap below cannot set the flag
    wr(TIMER2_CONTROL_ADDR, 8'h24);
    wr(COUNT_LOW_ADDR, 8'hFE);
    wr(COUNT_HIGH_ADDR, 8'hFF);
    wait_for(2);
    t1_req <= 1'b1;
    @(posedge clk) t1_req <= 1'b0;
    repeat (3) @(posedge clk);
    chk(8'(rxc), 8'h01);
    chk(8'(txc), 8'h01);
    rc(IRQ_STATUS_ADDR, 8'h00);
    wr(IRQ_ENABLE_ADDR, 8'h02);
    wr(TIMER2_CONTROL_ADDR, 8'h08);
    pin <= 1'b0;
    wait_for(1);
    chk({7'h00, irq}, 8'h01);
    rc(TIMER2_CONTROL_ADDR, 8'h48);
    wr(IRQ_CLEAR_ADDR, 8'h02);
    wr(TIMER2_CONTROL_ADDR, 8'h09);
    fall_pin();
    wait_for(3);
    wr(IRQ_CLEAR_ADDR, 8'h02);
    wr(MODE_ADDR, 8'h01);
    fall_pin();
    repeat (10) @(posedge clk);
    #1 chk({7'h00, irq}, 8'h00);
    wr(MODE_ADDR, 8'h00);
    wr(TIMER2_CONTROL_ADDR, 8'h06);
    wr(COUNT_LOW_ADDR, 8'h00);
    wr(COUNT_HIGH_ADDR, 8'h00);
    // counter mode: three falling edges on the count pin
    for (int i = 0; i < 3; i++) begin
      cpin <= 1'b0;
      repeat (6) @(posedge clk);
      cpin <= 1'b1;
      repeat (6) @(posedge clk);
    end
    rc(COUNT_LOW_ADDR, 8'h03);
    rc(COUNT_HIGH_ADDR, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
